// ==== laps_codec_pkg.sv ====
// Purpose: Shared constants, types and register layout of the LAPS frame codec
// Assumes: Byte-wide serial stream, 32-bit classic Wishbone register access
// Notes: All offsets are byte addresses of aligned 32-bit words
package laps_codec_pkg;
	// ======================================================================
	// Octet values on the line
	localparam logic [7:0] FLAG_OCTET = 8'h7e;  // Opening and closing flag
	localparam logic [7:0] ESC_OCTET = 8'h7d;   // Escape prefix
	localparam logic [7:0] ESC_FLAG = 8'h5e;    // Escaped flag
	localparam logic [7:0] ESC_ESC = 8'h5d;     // Escaped escape
	localparam logic [7:0] RATE_OCTET = 8'hdd;  // Rate adaptation follower
	localparam logic [7:0] ESC_XOR = 8'h20;     // Bit flipped by transparency
	// ======================================================================
	// Frame check and frame size
	localparam logic [31:0] CRC_POLY = 32'hedb88320;    // Reflected CRC-32
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3; // Good-frame remainder
	localparam logic [3:0] MIN_OCTETS = 4'h6;           // Shortest legal frame
	localparam logic [3:0] HDR_LAST = 4'hf;             // 16 inserted header octets
	localparam logic [1:0] FCS_LAST = 2'h3;             // 4 FCS octets
	localparam int SCR_LEN = 43;                        // x^43+1 delay line
	// ======================================================================
	// Register map (byte offsets) and reset values
	localparam int CFG_WORDS = 7;
	localparam logic [7:0] OFS_ENABLE = 8'h00;      // x86_enable_reg
	localparam logic [7:0] OFS_ADDR_MATCH = 8'h04;  // x86_address_match
	localparam logic [7:0] OFS_SAPI_MATCH = 8'h08;  // x86_sapi_match_low
	localparam logic [7:0] OFS_DEST_LO = 8'h0c;
	localparam logic [7:0] OFS_DEST_HI = 8'h10;
	localparam logic [7:0] OFS_SRC_LO = 8'h14;
	localparam logic [7:0] OFS_SRC_HI = 8'h18;
	localparam logic [7:0] OFS_COUNTS = 8'h1c;      // Frame counters, read only
	localparam logic [7:0] OFS_STATE = 8'h20;       // Live state, read only
	localparam int EN_X86 = 0;   // Encapsulation on
	localparam int EN_SCR = 1;   // Transmit scrambling on
	localparam int EN_DSCR = 2;  // Receive descrambling on
	localparam logic [31:0] CFG_RST [CFG_WORDS] = '{32'h00000000, 32'h00000304,
		32'h0000fe01, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
	localparam logic [31:0] CFG_MASK [CFG_WORDS] = '{32'h00000007, 32'h0000ffff,
		32'h0000ffff, 32'hffffffff, 32'h0000ffff, 32'hffffffff, 32'h0000ffff};
	localparam logic [7:0] TX_DIV_DEFAULT = 8'h08;  // Clocks per line octet
	// ======================================================================
	// Types
	typedef enum logic [1:0] {T_IDLE = 2'b00, T_HDR = 2'b01, T_PAY = 2'b10,
		T_FCS = 2'b11} tx_state_t;
	typedef enum logic {R_HUNT = 1'b0, R_FRAME = 1'b1} rx_state_t;
	typedef struct packed {
		logic [7:0] data;  // MAC octet
		logic last;        // Final octet of the MAC frame
	} tx_beat_t;
	typedef struct packed {
		logic [7:0] data;  // Frame octet, FCS included
		logic first;       // First octet after the start flag
		logic last;        // Final octet of the frame
		logic abort;       // Frame is bad, valid with last
	} rx_beat_t;
endpackage : laps_codec_pkg

// ==== laps_x86_frame_codec.sv ====
// Purpose: LAPS (X.86) encapsulation and decapsulation on a byte stream
// Assumes: Line partner runs on clk_sys; Wishbone classic slave for settings
// Notes: Receive frames leave with FCS octets kept and an abort tag on last
`timescale 1ns/10ps
`default_nettype none
module laps_x86_frame_codec #(
	parameter logic [7:0] TX_BYTE_DIV = laps_codec_pkg::TX_DIV_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire laps_codec_pkg::tx_beat_t tx_in,
	input wire logic tx_in_valid,
	output logic tx_in_ready,
	output logic [7:0] tx_line_data,
	output logic tx_byte_sync,
	input wire logic [7:0] rx_line_data,
	input wire logic rx_byte_sync,
	output laps_codec_pkg::rx_beat_t rx_out,
	output logic rx_out_valid
);
	import laps_codec_pkg::*;

	// ======================================================================
	// Helpers
	// One octet of reflected CRC-32, least significant bit first
	function automatic logic [31:0] crc_octet(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r >> 1) ^ (((r[0] ^ d[i]) == 1'b1) ? CRC_POLY : 32'h0);
		end
		return r;
	endfunction : crc_octet
	// Self-synchronous x^43+1, first line bit is the octet MSB
	// Returns {new delay line, output octet}; descrambling feeds the line bits
	function automatic logic [SCR_LEN+7:0] scr_octet(input logic [SCR_LEN-1:0] s,
		input logic [7:0] d, input logic descr);
		logic [SCR_LEN-1:0] q;
		logic [7:0] o;
		q = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			o[i] = d[i] ^ q[SCR_LEN-1];
			q = {q[SCR_LEN-2:0], (descr ? d[i] : o[i])};
		end
		return {q, o};
	endfunction : scr_octet

	// ======================================================================
	// Reset release through two flip-flops
	logic rst_meta; // First stage, read only by the second
	logic rst_n;    // Released reset for the rest of the block
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ======================================================================
	// Wishbone slave: one wait state, every address acknowledged
	logic [31:0] cfg [CFG_WORDS]; // Settings words
	logic [15:0] rx_good_cnt;     // Frames delivered clean
	logic [15:0] rx_abort_cnt;    // Frames delivered with abort
	tx_state_t tx_state;
	rx_state_t rx_state;
	logic rx_esc;                 // Previous receive octet was an escape
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [5:0] wb_word = wb_adr_i[7:2];
	wire [31:0] sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
		{8{wb_sel_i[0]}}};
	// Ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end
	// Settings words: byte lanes merged, unused bits kept zero
	for (genvar g = 0; g < CFG_WORDS; g++) begin : g_cfg
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				cfg[g] <= CFG_RST[g];
			end else if (wb_req && wb_we_i && wb_word == 6'(g)) begin
				cfg[g] <= ((cfg[g] & ~sel_mask) | (wb_dat_i & sel_mask)) & CFG_MASK[g];
			end
		end
	end
	// Read decode; unmapped words read zero
	logic [31:0] rd_word;
	always_comb begin
		if (wb_adr_i < OFS_COUNTS) begin
			rd_word = cfg[wb_word[2:0]];
		end else if (wb_adr_i[7:2] == OFS_COUNTS[7:2]) begin
			rd_word = {rx_abort_cnt, rx_good_cnt};
		end else if (wb_adr_i[7:2] == OFS_STATE[7:2]) begin
			rd_word = {28'h0, rx_esc, rx_state, tx_state};
		end else begin
			rd_word = 32'h0;
		end
	end
	// Read data registered with the ack
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0;
		end else if (wb_req) begin
			wb_dat_o <= wb_we_i ? 32'h0 : rd_word;
		end
	end
	// Named setting bits
	wire x86_en = cfg[0][EN_X86];   // Encapsulation active
	wire scr_en = cfg[0][EN_SCR];   // Transmit scrambling
	wire dscr_en = cfg[0][EN_DSCR]; // Receive descrambling
	wire [31:0] match_vec = {cfg[1][7:0], cfg[1][15:8], cfg[2][15:0]};
	wire [127:0] hdr_vec = {match_vec, cfg[4][15:0], cfg[3], cfg[6][15:0], cfg[5]};

	// ======================================================================
	// Transmit octet clock: one enable pulse per line octet
	logic [7:0] tx_div;
	wire tx_tick = (tx_div == TX_BYTE_DIV - 8'h01);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_div <= 8'h00;
		end else begin
			tx_div <= tx_tick ? 8'h00 : tx_div + 8'h01;
		end
	end

	// ======================================================================
	// Transmit framing
	logic [3:0] tx_idx;           // Header or FCS octet index
	logic [31:0] tx_crc;          // Running FCS
	logic esc_pend;               // Second octet of a pair is due
	logic [7:0] esc_byte;         // That second octet
	logic [SCR_LEN-1:0] scr_q;    // Scrambler delay line
	logic [7:0] tx_raw;           // Octet before transparency
	logic tx_is_data;             // Octet lies inside the FCS cover or is FCS
	logic tx_rate;                // No MAC octet ready: send a rate pair
	wire [31:0] fcs_word = ~tx_crc;
	// Octet source by state
	always_comb begin
		tx_raw = FLAG_OCTET;
		tx_is_data = 1'b0;
		tx_rate = 1'b0;
		case (tx_state)
			T_HDR: begin
				tx_raw = hdr_vec[8'd127 - {tx_idx, 3'b000} -: 8];
				tx_is_data = 1'b1;
			end
			T_PAY: begin
				tx_raw = tx_in.data;
				tx_is_data = tx_in_valid;
				tx_rate = ~tx_in_valid;
			end
			T_FCS: begin
				tx_raw = fcs_word[{tx_idx[1:0], 3'b000} +: 8];
				tx_is_data = 1'b1;
			end
			default: begin
				tx_raw = FLAG_OCTET; // Idle fill doubles as closing flag
			end
		endcase
	end

	wire tx_adv = tx_tick & ~esc_pend;
	wire need_esc = tx_rate | (tx_is_data & (tx_raw == FLAG_OCTET | tx_raw == ESC_OCTET));
	wire [7:0] slot_byte = esc_pend ? esc_byte : (need_esc ? ESC_OCTET : tx_raw);
	wire [SCR_LEN+7:0] scr_res = scr_octet(scr_q, slot_byte, 1'b0);
	assign tx_in_ready = tx_adv & (tx_state == T_PAY);
	// Escape pair bookkeeping
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			esc_pend <= 1'b0;
			esc_byte <= 8'h00;
		end else if (tx_tick) begin
			esc_pend <= tx_adv & need_esc;
			esc_byte <= tx_rate ? RATE_OCTET : tx_raw ^ ESC_XOR;
		end
	end
	// Frame sequencer advances once per unescaped slot
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= T_IDLE;
			tx_idx <= 4'h0;
			tx_crc <= CRC_INIT;
		end else if (tx_adv) begin
			case (tx_state)
				T_IDLE: begin
					if (x86_en && tx_in_valid) begin
						tx_state <= T_HDR;
						tx_idx <= 4'h0;
						tx_crc <= CRC_INIT;
					end
				end
				T_HDR: begin
					tx_crc <= crc_octet(tx_crc, tx_raw);
					tx_idx <= tx_idx + 4'h1;
					if (tx_idx == HDR_LAST) begin
						tx_state <= T_PAY;
					end
				end
				T_PAY: begin
					if (tx_in_valid) begin
						tx_crc <= crc_octet(tx_crc, tx_raw);
						if (tx_in.last) begin
							tx_state <= T_FCS;
							tx_idx <= 4'h0;
						end
					end
				end
				default: begin
					tx_idx <= tx_idx + 4'h1;
					if (tx_idx[1:0] == FCS_LAST) begin
						tx_state <= T_IDLE;
					end
				end
			endcase
		end
	end
	// Line output; the scrambler shifts every octet, enabled or not
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_line_data <= FLAG_OCTET;
			tx_byte_sync <= 1'b0;
			scr_q <= '0;
		end else begin
			tx_byte_sync <= tx_tick;
			if (tx_tick) begin
				scr_q <= scr_res[SCR_LEN+7:8];
				tx_line_data <= scr_en ? scr_res[7:0] : slot_byte;
			end
		end
	end
	// ======================================================================
	// Receive: descramble, delineate, strip pairs, check, tag
	logic [SCR_LEN-1:0] dscr_q; // Descrambler delay line
	logic [3:0] rx_cnt;         // Octets in frame, saturating
	logic [31:0] rx_crc;
	logic hdr_bad;              // Header octet mismatch seen
	logic pend_v;               // Held octet waits for its successor
	logic pend_first;
	logic [7:0] pend_data;
	wire [SCR_LEN+7:0] dscr_res = scr_octet(dscr_q, rx_line_data, 1'b1);
	wire [7:0] rx_d = dscr_en ? dscr_res[7:0] : rx_line_data;
	wire rx_in = rx_byte_sync & x86_en & (rx_state == R_FRAME);
	wire rx_open = rx_byte_sync & x86_en & (rx_state == R_HUNT) & (rx_d == FLAG_OCTET);
	wire esc_ok = rx_d == ESC_FLAG | rx_d == ESC_ESC;
	wire rx_acc = rx_in & (rx_esc ? esc_ok : ~(rx_d == ESC_OCTET | rx_d == FLAG_OCTET));
	wire rx_abt = rx_in & rx_esc & ~(esc_ok | rx_d == RATE_OCTET);
	wire rx_cls = rx_in & ~rx_esc & (rx_d == FLAG_OCTET) & (rx_cnt != 4'h0);
	wire [7:0] acc_byte = rx_esc ? rx_d ^ ESC_XOR : rx_d;
	wire [7:0] match_byte = match_vec[8'd31 - {2'b00, rx_cnt[1:0], 3'b000} -: 8];
	wire [31:0] crc_next = crc_octet(rx_crc, acc_byte);
	wire frame_bad = (rx_cnt < MIN_OCTETS) | (rx_crc != CRC_RESIDUE) | hdr_bad;
	wire rx_end = rx_cls | rx_abt;
	// Descrambler runs on every octet strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dscr_q <= '0;
		end else if (rx_byte_sync) begin
			dscr_q <= dscr_res[SCR_LEN+7:8];
		end
	end
	// Delineation and per-frame checks
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= R_HUNT;
			rx_esc <= 1'b0;
			rx_cnt <= 4'h0;
			rx_crc <= CRC_INIT;
			hdr_bad <= 1'b0;
		end else if (!x86_en) begin
			rx_state <= R_HUNT;
			rx_esc <= 1'b0;
		end else if (rx_open) begin
			rx_state <= R_FRAME;
			rx_cnt <= 4'h0;
			rx_crc <= CRC_INIT;
			hdr_bad <= 1'b0;
		end else if (rx_in) begin
			rx_esc <= ~rx_esc & (rx_d == ESC_OCTET);
			if (rx_abt) begin
				rx_state <= R_HUNT;
			end
			if (rx_end) begin
				rx_cnt <= 4'h0; // Flag also opens the next frame
				rx_crc <= CRC_INIT;
				hdr_bad <= 1'b0;
			end else if (rx_acc) begin
				rx_crc <= crc_next;
				rx_cnt <= (rx_cnt == 4'hf) ? rx_cnt : rx_cnt + 4'h1;
				if (rx_cnt < 4'h4 && acc_byte != match_byte) begin
					hdr_bad <= 1'b1;
				end
			end
		end
	end
	// One-octet holding stage so the last octet can carry the verdict
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_v <= 1'b0;
			pend_first <= 1'b0;
			pend_data <= 8'h00;
			rx_out <= '0;
			rx_out_valid <= 1'b0;
			rx_good_cnt <= 16'h0;
			rx_abort_cnt <= 16'h0;
		end else begin
			rx_out_valid <= pend_v & (rx_acc | rx_end);
			if (pend_v && (rx_acc || rx_end)) begin
				rx_out.data <= pend_data;
				rx_out.first <= pend_first;
				rx_out.last <= rx_end;
				rx_out.abort <= rx_abt | (rx_cls & frame_bad);
			end
			if (pend_v && rx_end) begin
				rx_good_cnt <= rx_good_cnt + {15'h0, ~(rx_abt | frame_bad)};
				rx_abort_cnt <= rx_abort_cnt + {15'h0, rx_abt | frame_bad};
			end
			if (rx_acc) begin
				pend_v <= 1'b1;
				pend_first <= (rx_cnt == 4'h0);
				pend_data <= acc_byte;
			end else if (rx_end || !x86_en) begin
				pend_v <= 1'b0; // Rate pairs leave the held octet alone
			end
		end
	end

	// ======================================================================
	// Checks
	sequence s_rx_esc_then(logic [7:0] v);
		rx_in && rx_esc && rx_d == v;
	endsequence
	chk_txsync_pulse: assert property (tx_byte_sync |=> !tx_byte_sync)
		else $error("tx_byte_sync held longer than one cycle");
	chk_tx_escape_pair: assert property (tx_adv && tx_is_data && tx_raw == FLAG_OCTET
		|=> esc_pend && esc_byte == ESC_FLAG ##1 tx_line_data == ESC_OCTET || scr_en)
		else $error("flag octet not escaped to 7d 5e");
	chk_tx_close_flag: assert property (tx_adv && tx_state == T_FCS && tx_idx[1:0] == FCS_LAST
		|=> tx_state == T_IDLE)
		else $error("closing flag not sent after FCS");
	chk_tx_plain_out: assert property (tx_tick && !scr_en |=> tx_byte_sync
		&& tx_line_data == $past(slot_byte))
		else $error("unscrambled octet altered");
	chk_rx_open_flag: assert property (rx_open |=> rx_state == R_FRAME)
		else $error("start flag did not open frame");
	chk_rx_rate_drop: assert property (rx_in && rx_esc && rx_d == RATE_OCTET
		|=> !rx_out_valid ##0 pend_v == $past(pend_v))
		else $error("rate adaptation pair passed on");
	chk_rx_unescape: assert property (s_rx_esc_then(ESC_FLAG) |=> pend_v
		&& pend_data == FLAG_OCTET)
		else $error("7d 5e not restored to 7e");
	chk_rx_abort_pair: assert property (s_rx_esc_then(FLAG_OCTET) |=> rx_state == R_HUNT)
		else $error("7d 7e did not abort");
	chk_rx_short_frame: assert property (rx_cls && pend_v && rx_cnt < MIN_OCTETS
		|=> rx_out_valid && rx_out.last && rx_out.abort)
		else $error("short frame not aborted");
	chk_rx_bad_escape: assert property (rx_abt && pend_v |=> rx_out_valid && rx_out.abort
		&& rx_state == R_HUNT)
		else $error("bad escape follower not aborted");
endmodule : laps_x86_frame_codec
`default_nettype wire

// ==== laps_line_partner.sv ====
// Purpose: Line-side partner of the LAPS codec, feeding and taking line octets
// Assumes: Same clock as the codec; receive strobes at most every other clock
// Notes: Off-strobe the receive data shows the inverse of the last octet
`timescale 1ns/10ps
`default_nettype none
module laps_line_partner (
	input wire logic clk_sys,
	input wire logic [7:0] tx_line_data,
	input wire logic tx_byte_sync,
	output logic [7:0] rx_line_data,
	output logic rx_byte_sync
);
	// ======================================================================
	// Queues and mode
	logic [7:0] send_q[$]; // Octets waiting for the receiver
	logic [7:0] seen_q[$]; // Octets taken from the transmitter
	logic loop_on = 1'b0; // Transmit line fed back into the receiver
	logic [7:0] last_oct = 8'h00; // Last octet driven, kept to invert it
	initial begin
		rx_line_data = 8'h00;
		rx_byte_sync = 1'b0;
	end
	// ======================================================================
	// Octet pacing
	// Stale data is inverted so a sample off the strobe cannot pass by luck
	always @(posedge clk_sys) begin
		logic [7:0] b;
		logic go;
		go = 1'b0;
		b = 8'h00;
		if (tx_byte_sync === 1'b1) begin
			seen_q.push_back(tx_line_data);
		end
		if (loop_on && tx_byte_sync === 1'b1) begin
			b = tx_line_data;
			go = 1'b1;
		end else if (!loop_on && send_q.size() > 0 && !rx_byte_sync) begin
			b = send_q.pop_front();
			go = 1'b1;
		end
		rx_byte_sync <= go; // One-cycle strobe marks each octet boundary
		rx_line_data <= go ? b : ~last_oct;
		if (go) begin
			last_oct <= b;
		end
	end
endmodule : laps_line_partner
`default_nettype wire

// ==== tb_laps_x86_frame_codec.sv ====
// Purpose: Self-checking bench for the LAPS frame codec
// Assumes: One 250 MHz clock; line partner model beside the codec
// Notes: Reset values and register rows first, then receive, abort, transmit, scrambled loop and byte lane cases
`timescale 1ns/10ps
`default_nettype none
module tb_laps_x86_frame_codec;
	import laps_codec_pkg::*;
	// ======================================================================
	// Signals
	logic clk_sys = 1'b0; // 4 ns clock
	logic resetn = 1'b0; // Active low reset
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hf; // Byte lanes of a write
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	tx_beat_t tx_in = '0;
	logic tx_in_valid = 1'b0;
	logic tx_in_ready, tx_byte_sync, rx_byte_sync, rx_out_valid;
	logic [7:0] tx_line_data, rx_line_data;
	rx_beat_t rx_out;
	int failures = 0;
	int check_count = 0;
	int k0; // First frame octet in the captured transmit line
	rx_beat_t rx_q[$]; // Beats delivered downstream
	logic [7:0] raw_q[$]; // Frame octets before escaping, FCS included
	logic [7:0] line_q[$]; // Escaped line octets with flags
	logic [31:0] rd; // Last read data
	// Ordinary register cases: address, write value, expected read back
	logic [7:0] row_adr [8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h40, 8'h1c};
	logic [31:0] row_wr [8] = '{32'hffff0304, 32'h1234fe01, 32'h7e7d5566, 32'habcd1122,
		32'h99aabbcc, 32'h55667788, 32'hffffffff, 32'hffffffff};
	logic [31:0] row_exp [8] = '{32'h00000304, 32'h0000fe01, 32'h7e7d5566, 32'h00001122,
		32'h99aabbcc, 32'h00007788, 32'h00000000, 32'h00000000};
	logic [7:0] mac [5] = '{8'h08, 8'h00, 8'h7e, 8'h7d, 8'h55};
	logic [7:0] hdr_tx [16] = '{8'h04, 8'h03, 8'hfe, 8'h01, 8'h11, 8'h22, 8'h7e, 8'h7d,
		8'h55, 8'h66, 8'h77, 8'h88, 8'h99, 8'haa, 8'hbb, 8'hcc};
	// ======================================================================
	// Design and partner
	laps_x86_frame_codec #(.TX_BYTE_DIV(8'h08)) dut_u (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.tx_in(tx_in),
		.tx_in_valid(tx_in_valid),
		.tx_in_ready(tx_in_ready),
		.tx_line_data(tx_line_data),
		.tx_byte_sync(tx_byte_sync),
		.rx_line_data(rx_line_data),
		.rx_byte_sync(rx_byte_sync),
		.rx_out(rx_out),
		.rx_out_valid(rx_out_valid)
	);
	laps_line_partner line_u (
		.clk_sys(clk_sys),
		.tx_line_data(tx_line_data),
		.tx_byte_sync(tx_byte_sync),
		.rx_line_data(rx_line_data),
		.rx_byte_sync(rx_byte_sync)
	);
	// ======================================================================
	// Clock, capture and watchdog
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (rx_out_valid === 1'b1) begin
			rx_q.push_back(rx_out);
		end
	end
	// About 1100 clocks are needed; some 27 times that means a hang
	initial begin
		repeat (30000) @(posedge clk_sys);
		failures++;
		report_and_stop();
	end
	// ======================================================================
	// Tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	// Classic single cycle; held until ack is sampled high
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge clk_sys);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_cycle
	task automatic base_raw();
		raw_q = {8'h04, 8'h03, 8'hfe, 8'h01, 8'h7e, 8'h7d, 8'h11, 8'h22, 8'h33};
	endtask : base_raw
	// Appends the FCS, escapes, optionally inserts a rate pair, adds flags
	task automatic build_frame(input logic [31:0] spoil, input logic rate);
		logic [31:0] c;
		c = CRC_INIT;
		foreach (raw_q[i]) begin
			c = c ^ {24'h0, raw_q[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		c = ~c ^ spoil;
		for (int i = 0; i < 4; i++) raw_q.push_back(c[8*i +: 8]);
		line_q = {FLAG_OCTET};
		foreach (raw_q[i]) begin
			if (raw_q[i] == FLAG_OCTET || raw_q[i] == ESC_OCTET) begin
				line_q.push_back(ESC_OCTET);
				line_q.push_back(raw_q[i] ^ ESC_XOR);
			end else begin
				line_q.push_back(raw_q[i]);
			end
			if (rate && i == 5) begin
				line_q.push_back(ESC_OCTET);
				line_q.push_back(RATE_OCTET);
			end
		end
		line_q.push_back(FLAG_OCTET);
	endtask : build_frame
	task automatic rx_send();
		rx_q.delete();
		foreach (line_q[i]) line_u.send_q.push_back(line_q[i]);
		while (line_u.send_q.size() > 0) begin
			@(posedge clk_sys);
		end
		repeat (6) @(posedge clk_sys);
	endtask : rx_send
	task automatic check_rx_good();
		check("rx beat count", rx_q.size(), raw_q.size());
		foreach (raw_q[i]) if (i < rx_q.size()) check("rx octet", rx_q[i].data, raw_q[i]);
		check("rx first", rx_q[0].first, 1'b1);
		check("rx end", {rx_q[$].last, rx_q[$].abort}, 2'b10);
	endtask : check_rx_good
	// Offers the MAC octets, holding each until ready is sampled high
	task automatic send_mac();
		int i;
		i = 0;
		@(posedge clk_sys);
		tx_in <= '{data: mac[0], last: 1'b0};
		tx_in_valid <= 1'b1;
		while (i < 5) begin
			@(posedge clk_sys);
			if (tx_in_ready === 1'b1) begin
				i++;
				if (i < 5) tx_in <= '{data: mac[i % 5], last: (i == 4)};
				else tx_in_valid <= 1'b0;
			end
		end
	endtask : send_mac
	// ======================================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		check("tx idle in reset", tx_line_data, FLAG_OCTET);
		check("rx valid in reset", rx_out_valid, 1'b0);
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (5) @(posedge clk_sys);
		for (int i = 0; i < CFG_WORDS; i++) begin
			wb_cycle(1'b0, 8'(4 * i), 32'h0);
			check("reset value", rd, CFG_RST[i]);
		end
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			wb_cycle(1'b1, row_adr[i], row_wr[i]);
			wb_cycle(1'b0, row_adr[i], 32'h0);
			check("register row", rd, row_exp[i]);
		end
		$display("test register rows done");
		// Encapsulation off: a good frame must not come out
		base_raw();
		build_frame(32'h0, 1'b1);
		rx_send();
		check("rx beats while off", rx_q.size(), 0);
		wb_cycle(1'b1, OFS_ENABLE, 32'h1);
		rx_send();
		check_rx_good();
		$display("test receive good frame done");
		// Abort kinds: 7d 7e, bad FCS, short, wrong header, bad escape
		for (int k = 0; k < 5; k++) begin
			base_raw();
			if (k == 3) raw_q[0] = 8'h05;
			build_frame(k == 1 ? 32'h00000100 : 32'h0, 1'b0);
			if (k == 0) line_q = {line_q[0:8], ESC_OCTET, FLAG_OCTET};
			if (k == 2) line_q = {FLAG_OCTET, 8'h04, 8'h03, 8'hfe, FLAG_OCTET};
			if (k == 4) line_q = {line_q[0:4], ESC_OCTET, 8'h11};
			rx_send();
			check("rx abort", {rx_q[$].last, rx_q[$].abort}, 2'b11);
		end
		wb_cycle(1'b0, OFS_COUNTS, 32'h0);
		check("frame counts", rd, 32'h00050001);
		$display("test receive aborts done");
		// Plain transmit: header from settings, escapes, FCS, closing flag
		raw_q = {};
		foreach (hdr_tx[i]) raw_q.push_back(hdr_tx[i]);
		foreach (mac[i]) raw_q.push_back(mac[i]);
		build_frame(32'h0, 1'b0);
		line_u.seen_q.delete();
		send_mac();
		for (int n = 0; n < 4000; n++) begin
			@(posedge clk_sys);
			k0 = 0;
			while (k0 < line_u.seen_q.size() && line_u.seen_q[k0] == FLAG_OCTET) k0++;
			if (line_u.seen_q.size() >= k0 + line_q.size() - 1) break;
		end
		foreach (line_q[i]) if (i > 0) check("tx line", line_u.seen_q[k0 + i - 1], line_q[i]);
		$display("test transmit frame done");
		// Scrambled loop: line must look scrambled, frame must come back whole
		wb_cycle(1'b1, OFS_ENABLE, 32'h7);
		line_u.loop_on <= 1'b1;
		repeat (200) @(posedge clk_sys);
		line_u.seen_q.delete();
		repeat (40) @(posedge clk_sys);
		rd = {line_u.seen_q[0], line_u.seen_q[1], line_u.seen_q[2], line_u.seen_q[3]};
		check("scrambled idle", rd == 32'h7e7e7e7e, 1'b0);
		rx_q.delete();
		send_mac();
		for (int n = 0; n < 4000 && !(rx_q.size() > 0 && rx_q[$].last === 1'b1); n++) begin
			@(posedge clk_sys);
		end
		check_rx_good();
		$display("test scrambled loop done");
		// Byte lane merge: only lane 1 of the destination word changes
		wb_sel_i <= 4'h2;
		wb_cycle(1'b1, OFS_DEST_LO, 32'h0000ab00);
		wb_sel_i <= 4'hf;
		wb_cycle(1'b0, OFS_DEST_LO, 32'h0);
		check("lane merge", rd, 32'h7e7dab66);
		$display("test byte lanes done");
		report_and_stop();
	end
endmodule : tb_laps_x86_frame_codec
`default_nettype wire
